// ---- logic/tcls_top.sv ----
// commit register, led register and demand priority statistics counters
`timescale 1ns/1ps
module tcls_top
  import tcls_pkg::*;
(
  input wire logic CLK,
  input wire logic ARST_N,
  input wire tcls_dio_req_t DIO_REQ,
  output logic [31:0] DIO_RDATA,
  output logic DIO_RVALID,
  input wire tcls_stat_ev_t STAT_EVENTS,
  input wire logic MEDIA_RX_ERROR_PIN,
  input wire logic ADAPTER_RESET,
  input wire logic HOST_BUS_RESET_N,
  input wire logic ADAPTER_RUN_CONTROL,
  input wire logic BIT_RATE_PHY_SELECT,
  input wire logic [11:0] TX_FIFO_BYTES,
  input wire logic TX_FRAME_IN_FIFO,
  input wire logic TX_WAIT_DATA,
  input wire logic DMA_WAIT_SPACE,
  output logic TX_START_OK,
  output logic [3:0] TX_COMMIT_LEVEL,
  output logic MEDIA_TX_NIBBLE_BIT3,
  output logic MEDIA_TX_NIBBLE_BIT2,
  output logic MEDIA_TX_NIBBLE_BIT1,
  output logic MEDIA_TX_ERROR_PIN,
  input wire logic EXPANSION_HIGH_LATCH_EN,
  input wire logic EXPANSION_LOW_LATCH_EN,
  input wire logic EXPANSION_OUTPUT_EN_N,
  output logic [7:0] EXPANSION_ADDR_DATA_PINS_O,
  output logic EXPANSION_ADDR_DATA_PINS_OE,
  output logic STATS_OVF_INT,
  output logic [2:0] STATS_INT_TYPE
);
  logic soft_clr;
  logic commit_wr;
  logic led_wr;
  logic rom_busy;
  logic rx_err_seen_reg;
  logic rx_err_any;
  logic [NUM_CTR-1:0] ctr_inc;
  logic [NUM_CTR-1:0] err_msb;
  logic [23:0] ctr_val [NUM_CTR];
  logic [7:0] led_reg;
  logic [31:0] rdata_next;
  tcls_commit_t commit;

  // adapter reset and bus reset both clear the soft registers synchronously
  assign soft_clr = ADAPTER_RESET || !HOST_BUS_RESET_N;

  // write strobes need the byte lane that holds the register
  assign commit_wr = DIO_REQ.wr && DIO_REQ.addr == OFS_COMMIT && DIO_REQ.be[COMMIT_LANE];
  assign led_wr = DIO_REQ.wr && DIO_REQ.addr == OFS_LED && DIO_REQ.be[LED_LANE];

  // receive error pin may pulse anywhere in the frame, so hold it to frame end
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rx_err_seen_reg <= 1'b0;
    end else if (STAT_EVENTS.rx_frame_end) begin
      rx_err_seen_reg <= 1'b0;
    end else if (MEDIA_RX_ERROR_PIN) begin
      rx_err_seen_reg <= 1'b1;
    end
  end

  assign rx_err_any = rx_err_seen_reg || MEDIA_RX_ERROR_PIN;

  // counter increments; crc only counts when no alignment or code error
  always_comb begin
    ctr_inc[0] = STAT_EVENTS.rx_good;
    ctr_inc[1] = STAT_EVENTS.rx_overrun;
    ctr_inc[2] = STAT_EVENTS.tx_good;
    ctr_inc[3] = STAT_EVENTS.tx_underrun;
    ctr_inc[4] = STAT_EVENTS.rx_frame_end && STAT_EVENTS.rx_crc_err
                 && !STAT_EVENTS.rx_odd_nibble && !rx_err_any;
    ctr_inc[5] = STAT_EVENTS.rx_frame_end
                 && (STAT_EVENTS.rx_odd_nibble || rx_err_any);
  end

  // counters; a read clears only the byte lanes that were enabled
  for (genvar i = 0; i < NUM_CTR; i++) begin : g_ctr
    localparam int W = ctr_width(i);
    logic [W/8-1:0] clr;
    logic [W-1:0] val;
    for (genvar k = 0; k < W / 8; k++) begin : g_lane
      assign clr[k] = DIO_REQ.rd && DIO_REQ.addr == ctr_ofs(i)
                      && DIO_REQ.be[ctr_lane(i) + k];
    end
    tcls_stat_ctr #(
      .W(W)
    ) u_ctr (
      .clk(CLK),
      .arst_n(ARST_N),
      .inc(ctr_inc[i]),
      .clr_bytes(clr),
      .value(val)
    );
    assign ctr_val[i] = 24'(val);
    assign err_msb[i] = ctr_is_err(i) ? val[W-1] : 1'b0;
  end

  tcls_commit u_commit (
    .clk(CLK),
    .arst_n(ARST_N),
    .soft_clr(soft_clr),
    .wr_en(commit_wr),
    .wr_byte(DIO_REQ.wdata[COMMIT_LANE*8 +: 8]),
    .run_ctl(ADAPTER_RUN_CONTROL),
    .underrun(STAT_EVENTS.tx_underrun),
    .fifo_bytes(TX_FIFO_BYTES),
    .frame_in_fifo(TX_FRAME_IN_FIFO),
    .tx_wait_data(TX_WAIT_DATA),
    .dma_wait_space(DMA_WAIT_SPACE),
    .commit(commit),
    .start_ok(TX_START_OK)
  );

  assign TX_COMMIT_LEVEL = commit.level;

  // led register, writable at any time except while a soft reset is held
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      led_reg <= LED_RESET;
    end else if (soft_clr) begin
      led_reg <= LED_RESET;
    end else if (led_wr) begin
      led_reg <= DIO_REQ.wdata[LED_LANE*8 +: 8];
    end
  end

  // read mux; counter reads see the value from before the clear
  always_comb begin
    rdata_next = 32'h0000_0000;
    for (int i = 0; i < NUM_CTR; i++) begin
      if (DIO_REQ.addr == ctr_ofs(i)) begin
        rdata_next = rdata_next | ({8'h00, ctr_val[i]} << (8 * ctr_lane(i)));
      end
    end
    if (DIO_REQ.addr == OFS_COMMIT) begin
      rdata_next[COMMIT_LANE*8 +: 8] = commit;
    end
    if (DIO_REQ.addr == OFS_LED) begin
      rdata_next[LED_LANE*8 +: 8] = led_reg;
    end
    for (int b = 0; b < 4; b++) begin
      if (!DIO_REQ.be[b]) begin
        rdata_next[b*8 +: 8] = 8'h00;
      end
    end
  end

  // read data one cycle after the strobe; unmapped bytes read zero
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      DIO_RDATA <= 32'h0000_0000;
      DIO_RVALID <= 1'b0;
    end else begin
      DIO_RVALID <= DIO_REQ.rd;
      if (DIO_REQ.rd) begin
        DIO_RDATA <= rdata_next;
      end
    end
  end

  // option bits reach the mii pins only in bit-rate mode, else held low
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      MEDIA_TX_NIBBLE_BIT3 <= 1'b0;
      MEDIA_TX_NIBBLE_BIT2 <= 1'b0;
      MEDIA_TX_NIBBLE_BIT1 <= 1'b0;
      MEDIA_TX_ERROR_PIN <= 1'b0;
    end else begin
      MEDIA_TX_NIBBLE_BIT3 <= BIT_RATE_PHY_SELECT && commit.phy_opt[PHY_FDX_DIS_BIT];
      MEDIA_TX_NIBBLE_BIT2 <= BIT_RATE_PHY_SELECT && commit.phy_opt[PHY_LOOP_BIT];
      MEDIA_TX_NIBBLE_BIT1 <= BIT_RATE_PHY_SELECT && commit.phy_opt[PHY_MEDIA_BIT];
      MEDIA_TX_ERROR_PIN <= BIT_RATE_PHY_SELECT && commit.phy_opt[PHY_RSVD_BIT];
    end
  end

  // enable follows the rom strobes directly so the bus never sees contention
  assign rom_busy = EXPANSION_HIGH_LATCH_EN || EXPANSION_LOW_LATCH_EN
                    || !EXPANSION_OUTPUT_EN_N;
  assign EXPANSION_ADDR_DATA_PINS_OE = !rom_busy;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      EXPANSION_ADDR_DATA_PINS_O <= ~LED_RESET;
    end else begin
      EXPANSION_ADDR_DATA_PINS_O <= ~led_reg;
    end
  end

  // overflow level from error counter msbs, cleared by reading them
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      STATS_OVF_INT <= 1'b0;
      STATS_INT_TYPE <= 3'h0;
    end else begin
      STATS_OVF_INT <= |err_msb;
      STATS_INT_TYPE <= (|err_msb) ? INT_TYPE_STATS : 3'h0;
    end
  end

  property p_led_pins;
    @(posedge CLK) disable iff (!ARST_N)
      led_wr && !soft_clr |=> ##1 (EXPANSION_ADDR_DATA_PINS_O == ~$past(DIO_REQ.wdata[7:0], 2));
  endproperty
  a_led_pins: assert property (p_led_pins) else $error("led pins not inverted value");

  property p_led_oe;
    @(posedge CLK) disable iff (!ARST_N)
      EXPANSION_ADDR_DATA_PINS_OE == !(EXPANSION_HIGH_LATCH_EN || EXPANSION_LOW_LATCH_EN
                                       || !EXPANSION_OUTPUT_EN_N);
  endproperty
  a_led_oe: assert property (p_led_oe) else $error("pin enable wrong for rom state");

  property p_soft_clr;
    @(posedge CLK) disable iff (!ARST_N)
      soft_clr |=> (led_reg == LED_RESET) && (commit == COMMIT_RESET);
  endproperty
  a_soft_clr: assert property (p_soft_clr) else $error("soft reset left bits set");

  property p_underrun_bump;
    @(posedge CLK) disable iff (!ARST_N)
      (STAT_EVENTS.tx_underrun && !commit_wr && !soft_clr && commit.level < LVL_MAX)
        |=> (commit.level == $past(commit.level) + 4'h1);
  endproperty
  a_underrun_bump: assert property (p_underrun_bump) else $error("level not bumped");

  property p_rsvd_pin;
    @(posedge CLK) disable iff (!ARST_N)
      !MEDIA_TX_ERROR_PIN && (commit.phy_opt[PHY_RSVD_BIT] == 1'b0);
  endproperty
  a_rsvd_pin: assert property (p_rsvd_pin) else $error("reserved option bit set");

  property p_phy_pins;
    @(posedge CLK) disable iff (!ARST_N)
      BIT_RATE_PHY_SELECT |=> MEDIA_TX_NIBBLE_BIT3 == $past(commit.phy_opt[PHY_FDX_DIS_BIT])
        && MEDIA_TX_NIBBLE_BIT1 == $past(commit.phy_opt[PHY_MEDIA_BIT]);
  endproperty
  a_phy_pins: assert property (p_phy_pins) else $error("option bits not on pins");

  property p_good_tx;
    @(posedge CLK) disable iff (!ARST_N)
      (STAT_EVENTS.tx_good && !(DIO_REQ.rd && DIO_REQ.addr == OFS_STAT_TX))
        |=> ctr_val[2] == 24'($past(ctr_val[2]) + 24'h000001);
  endproperty
  a_good_tx: assert property (p_good_tx) else $error("good tx not counted");

  property p_crc_only;
    @(posedge CLK) disable iff (!ARST_N)
      (STAT_EVENTS.rx_frame_end && STAT_EVENTS.rx_crc_err && MEDIA_RX_ERROR_PIN
       && !(DIO_REQ.rd && DIO_REQ.addr == OFS_STAT_ERR))
        |=> (ctr_val[4] == $past(ctr_val[4]))
            && (ctr_val[5][7:0] == 8'($past(ctr_val[5][7:0]) + 8'h01));
  endproperty
  a_crc_only: assert property (p_crc_only) else $error("code error frame miscounted");

  property p_read_clear;
    @(posedge CLK) disable iff (!ARST_N)
      (DIO_REQ.rd && DIO_REQ.addr == OFS_STAT_RX && DIO_REQ.be == 4'h1 && !ctr_inc[0])
        |=> ctr_val[0][7:0] == 8'h00 && ctr_val[0][23:8] == $past(ctr_val[0][23:8])
            && DIO_RVALID && DIO_RDATA[7:0] == $past(ctr_val[0][7:0]);
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("byte read clear wrong");

  property p_ovf;
    @(posedge CLK) disable iff (!ARST_N)
      ctr_val[3][7] |=> STATS_OVF_INT && STATS_INT_TYPE == INT_TYPE_STATS;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow not raised");

  property p_no_ovf;
    @(posedge CLK) disable iff (!ARST_N)
      !(|err_msb) |=> !STATS_OVF_INT && STATS_INT_TYPE == 3'h0;
  endproperty
  a_no_ovf: assert property (p_no_ovf) else $error("spurious overflow");

  property p_commit_thr;
    @(posedge CLK) disable iff (!ARST_N)
      (commit.level == 4'h0 && TX_FIFO_BYTES == 12'h03F && !TX_WAIT_DATA) |-> !TX_START_OK;
  endproperty
  a_commit_thr: assert property (p_commit_thr) else $error("started below 64 bytes");

  property p_rd_valid;
    @(posedge CLK) disable iff (!ARST_N)
      DIO_REQ.rd |=> DIO_RVALID;
  endproperty
  a_rd_valid: assert property (p_rd_valid) else $error("read valid missing");

  property p_media_off;
    @(posedge CLK) disable iff (!ARST_N)
      !BIT_RATE_PHY_SELECT |=> !(MEDIA_TX_NIBBLE_BIT3 || MEDIA_TX_NIBBLE_BIT2
                                 || MEDIA_TX_NIBBLE_BIT1 || MEDIA_TX_ERROR_PIN);
  endproperty
  a_media_off: assert property (p_media_off) else $error("media pins driven off mode");

  property p_led_write;
    @(posedge CLK) disable iff (!ARST_N)
      led_wr && !soft_clr |=> led_reg == $past(DIO_REQ.wdata[LED_LANE*8 +: 8]);
  endproperty
  a_led_write: assert property (p_led_write) else $error("led value not stored");

  property p_ctr_wr_ignored;
    @(posedge CLK) disable iff (!ARST_N)
      (DIO_REQ.wr && !DIO_REQ.rd && DIO_REQ.addr == OFS_STAT_RX && !STAT_EVENTS.rx_good
       && !STAT_EVENTS.rx_overrun)
        |=> ctr_val[0] == $past(ctr_val[0]) && ctr_val[1] == $past(ctr_val[1]);
  endproperty
  a_ctr_wr_ignored: assert property (p_ctr_wr_ignored) else $error("counter written");
endmodule : tcls_top

// ---- logic/tcls_pkg.sv ----
// constants, types and helpers shared by the commit/led/statistics block
package tcls_pkg;
  localparam logic [7:0] OFS_STAT_RX = 8'h30;
  localparam logic [7:0] OFS_STAT_TX = 8'h34;
  localparam logic [7:0] OFS_STAT_ERR = 8'h38;
  localparam logic [7:0] OFS_COMMIT = 8'h40;
  localparam logic [7:0] OFS_LED = 8'h44;
  localparam int COMMIT_LANE = 3;
  localparam int LED_LANE = 0;
  localparam int PHY_FDX_DIS_BIT = 3;
  localparam int PHY_LOOP_BIT = 2;
  localparam int PHY_MEDIA_BIT = 1;
  localparam int PHY_RSVD_BIT = 0;
  localparam logic [7:0] COMMIT_RESET = 8'h00;
  localparam logic [7:0] LED_RESET = 8'h00;
  localparam logic [3:0] LVL_MAX = 4'h7;
  localparam logic [3:0] LVL_DEADLOCK_MIN = 4'h3;
  localparam logic [3:0] LVL_WHOLE_MIN = 4'h5;
  localparam logic [11:0] COMMIT_BASE_BYTES = 12'h040;
  localparam logic [2:0] INT_TYPE_STATS = 3'h2;
  localparam int NUM_CTR = 6;

  typedef struct packed {
    logic tx_good;
    logic tx_underrun;
    logic rx_good;
    logic rx_overrun;
    logic rx_frame_end;
    logic rx_crc_err;
    logic rx_odd_nibble;
  } tcls_stat_ev_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [3:0] be;
    logic rd;
    logic wr;
    logic [31:0] wdata;
  } tcls_dio_req_t;

  typedef struct packed {
    logic [3:0] level;
    logic [3:0] phy_opt;
  } tcls_commit_t;

  // counter order: good rx, rx overrun, good tx, tx underrun, crc, code
  function automatic int ctr_width(input int i);
    return (i == 0 || i == 2) ? 24 : 8;
  endfunction : ctr_width

  function automatic logic [7:0] ctr_ofs(input int i);
    return (i < 2) ? OFS_STAT_RX : (i < 4) ? OFS_STAT_TX : OFS_STAT_ERR;
  endfunction : ctr_ofs

  function automatic int ctr_lane(input int i);
    return (i == 0 || i == 2) ? 0 : (i == 4) ? 2 : 3;
  endfunction : ctr_lane

  function automatic logic ctr_is_err(input int i);
    return !(i == 0 || i == 2);
  endfunction : ctr_is_err
endpackage : tcls_pkg

// ---- logic/tcls_stat_ctr.sv ----
// one statistics counter with per-byte clear on read
`timescale 1ns/1ps
module tcls_stat_ctr
  import tcls_pkg::*;
#(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic inc,
  input wire logic [W/8-1:0] clr_bytes,
  output logic [W-1:0] value
);
  logic [W-1:0] kept;

  // cleared bytes restart from zero; an event in the same cycle still counts
  always_comb begin
    kept = value;
    for (int k = 0; k < W / 8; k++) begin
      if (clr_bytes[k]) begin
        kept[k*8 +: 8] = 8'h00;
      end
    end
  end

  // natural wrap; on the error counters the msb has already flagged overflow
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      value <= '0;
    end else begin
      value <= kept + {{(W-1){1'b0}}, inc};
    end
  end

  property p_ctr_wrap;
    @(posedge clk) disable iff (!arst_n)
      (inc && (clr_bytes == '0) && (&value)) |=> (value == '0);
  endproperty
  a_ctr_wrap: assert property (p_ctr_wrap) else $error("counter did not wrap");

  property p_ctr_clear;
    @(posedge clk) disable iff (!arst_n)
      (!inc && (&clr_bytes)) |=> (value == '0);
  endproperty
  a_ctr_clear: assert property (p_ctr_clear) else $error("read did not clear");
endmodule : tcls_stat_ctr

// ---- logic/tcls_commit.sv ----
// adaptive transmit commit level and phy option bits
`timescale 1ns/1ps
module tcls_commit
  import tcls_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic soft_clr,
  input wire logic wr_en,
  input wire logic [7:0] wr_byte,
  input wire logic run_ctl,
  input wire logic underrun,
  input wire logic [11:0] fifo_bytes,
  input wire logic frame_in_fifo,
  input wire logic tx_wait_data,
  input wire logic dma_wait_space,
  output tcls_commit_t commit,
  output logic start_ok
);
  logic [3:0] level_base;
  logic [11:0] need_bytes;
  logic deadlock;
  logic [3:0] level_reg;
  logic [3:0] phy_opt_reg;

  // software load only while halted, then the underrun bump on top
  always_comb begin
    level_base = (wr_en && !run_ctl) ? wr_byte[7:4] : level_reg;
  end

  // codes above seven written by software stay put rather than wrap to zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      level_reg <= COMMIT_RESET[7:4];
    end else if (soft_clr) begin
      level_reg <= COMMIT_RESET[7:4];
    end else if (underrun && level_base < LVL_MAX) begin
      level_reg <= level_base + 4'h1;
    end else begin
      level_reg <= level_base;
    end
  end

  // reserved option bit is forced low whatever software writes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      phy_opt_reg <= COMMIT_RESET[3:0];
    end else if (soft_clr) begin
      phy_opt_reg <= COMMIT_RESET[3:0];
    end else if (wr_en) begin
      phy_opt_reg <= {wr_byte[3:1], 1'b0};
    end
  end

  // one driver for the whole register byte
  assign commit = '{level: level_reg, phy_opt: phy_opt_reg};

  // fill threshold doubles per code; large codes wait for the whole frame
  always_comb begin
    need_bytes = COMMIT_BASE_BYTES << commit.level[2:0];
    deadlock = (commit.level >= LVL_DEADLOCK_MIN) && tx_wait_data && dma_wait_space;
    if (commit.level >= LVL_WHOLE_MIN) begin
      start_ok = frame_in_fifo || deadlock;
    end else begin
      start_ok = (fifo_bytes >= need_bytes) || deadlock;
    end
  end

  property p_sat;
    @(posedge clk) disable iff (!arst_n)
      (commit.level == LVL_MAX && underrun && !wr_en && !soft_clr) |=> (commit.level == LVL_MAX);
  endproperty
  a_sat: assert property (p_sat) else $error("commit level left code seven");

  property p_locked;
    @(posedge clk) disable iff (!arst_n)
      (wr_en && run_ctl && !underrun && !soft_clr) |=> (commit.level == $past(commit.level));
  endproperty
  a_locked: assert property (p_locked) else $error("level written while running");

  property p_deadlock;
    @(posedge clk) disable iff (!arst_n)
      (commit.level >= LVL_DEADLOCK_MIN && tx_wait_data && dma_wait_space) |-> start_ok;
  endproperty
  a_deadlock: assert property (p_deadlock) else $error("deadlock not broken");
endmodule : tcls_commit

// ---- dv/tcls_phy_model.sv ----
// behavioural phy that picks up its option straps from the media transmit pins
`timescale 1ns/1ps
module tcls_phy_model (
  input wire logic clk,
  input wire logic opt_fdx_dis,
  input wire logic opt_loop,
  input wire logic opt_media,
  input wire logic opt_rsvd,
  input wire logic err_cmd,
  output logic rx_err,
  output logic [3:0] opts
);
  // options sampled every rising edge, as a strapped phy sees them; one cycle of extra lag
  always_ff @(posedge clk) begin
    opts <= {opt_fdx_dis, opt_loop, opt_media, opt_rsvd};
  end

  // receive error is a level commanded by the bench, cycle by cycle
  assign rx_err = err_cmd;
endmodule : tcls_phy_model

// ---- dv/tb_top.sv ----
// self-checking bench for the commit, led and statistics block
`timescale 1ns/1ps
module tb_top;
  import tcls_pkg::*;
  logic clk, arst_n, rvalid, rx_err_cmd, rx_err_pin, adp_rst, bus_rst_n, run_ctl, bit_rate_phy_select;
  logic frame_in, wait_data, wait_space, start_ok, ovf, b3, b2, b1, txer, oe, hle, lle, oe_n;
  logic [11:0] fifo_bytes;
  logic [31:0] rdata, lfsr, r;
  logic [3:0] level, opts;
  logic [7:0] pins;
  logic [2:0] itype;
  tcls_dio_req_t req;
  tcls_stat_ev_t ev;
  int errors, samples_checked, m_lvl, thr;
  int m_ctr[6]; // good rx, overrun, good tx, underrun, crc, code
  logic m_seen;

  tcls_top tcls_top_i (.CLK(clk), .ARST_N(arst_n), .DIO_REQ(req), .DIO_RDATA(rdata),
    .DIO_RVALID(rvalid), .STAT_EVENTS(ev), .MEDIA_RX_ERROR_PIN(rx_err_pin),
    .ADAPTER_RESET(adp_rst), .HOST_BUS_RESET_N(bus_rst_n), .ADAPTER_RUN_CONTROL(run_ctl),
    .BIT_RATE_PHY_SELECT(bit_rate_phy_select), .TX_FIFO_BYTES(fifo_bytes), .TX_FRAME_IN_FIFO(frame_in),
    .TX_WAIT_DATA(wait_data), .DMA_WAIT_SPACE(wait_space), .TX_START_OK(start_ok),
    .TX_COMMIT_LEVEL(level), .MEDIA_TX_NIBBLE_BIT3(b3), .MEDIA_TX_NIBBLE_BIT2(b2),
    .MEDIA_TX_NIBBLE_BIT1(b1), .MEDIA_TX_ERROR_PIN(txer), .EXPANSION_HIGH_LATCH_EN(hle),
    .EXPANSION_LOW_LATCH_EN(lle), .EXPANSION_OUTPUT_EN_N(oe_n),
    .EXPANSION_ADDR_DATA_PINS_O(pins), .EXPANSION_ADDR_DATA_PINS_OE(oe),
    .STATS_OVF_INT(ovf), .STATS_INT_TYPE(itype));

  tcls_phy_model tcls_phy_model_i (.clk(clk), .opt_fdx_dis(b3), .opt_loop(b2), .opt_media(b1),
    .opt_rsvd(txer), .err_cmd(rx_err_cmd), .rx_err(rx_err_pin), .opts(opts));

  // free-running 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd

  function automatic logic m_ovf();
    return ((m_ctr[1] | m_ctr[3] | m_ctr[4] | m_ctr[5]) & 32'h80) != 0;
  endfunction : m_ovf

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // bus cycles: request launched and dropped on falling edges
  task automatic bus_wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(negedge clk);
    req = '{addr: a, be: be, rd: 1'b0, wr: 1'b1, wdata: d};
    @(negedge clk);
    req.wr = 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input logic [7:0] a, input logic [3:0] be, input logic [31:0] exp);
    @(negedge clk);
    req = '{addr: a, be: be, rd: 1'b1, wr: 1'b0, wdata: 32'h0};
    @(negedge clk);
    req.rd = 1'b0;
    chk({31'h0, rvalid}, 32'h1);
    chk(rdata, exp);
  endtask : bus_rd

  // one cycle of statistics events, mirrored into the reference counters
  task automatic step(input tcls_stat_ev_t e, input logic err);
    @(negedge clk);
    ev = e;
    rx_err_cmd = err;
    m_ctr[0] += e.rx_good;
    m_ctr[1] += e.rx_overrun;
    m_ctr[2] += e.tx_good;
    m_ctr[3] += e.tx_underrun;
    if (e.tx_underrun && m_lvl < 7) m_lvl++;
    if (e.rx_frame_end && (e.rx_odd_nibble || m_seen || err)) m_ctr[5]++;
    else if (e.rx_frame_end && e.rx_crc_err) m_ctr[4]++;
    m_seen = e.rx_frame_end ? 1'b0 : (m_seen | err);
    for (int i = 0; i < 6; i++) m_ctr[i] &= (i == 0 || i == 2) ? 32'hFFFFFF : 32'hFF;
  endtask : step

  // overflow flag lags the event by two edges
  task automatic chk_ovf();
    step('0, 1'b0);
    step('0, 1'b0);
    chk({28'h0, ovf, itype}, {28'h0, m_ovf(), m_ovf() ? 3'h2 : 3'h0});
  endtask : chk_ovf

  task automatic results();
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results

  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    #50000;
    errors++;
    results();
  end

  initial begin
    lfsr = 32'hA2E2E4CD;
    req = '0;
    ev = '0;
    {rx_err_cmd, adp_rst, run_ctl, bit_rate_phy_select, frame_in, wait_data, wait_space} = '0;
    {hle, lle, oe_n, bus_rst_n} = 4'hF;
    fifo_bytes = 12'h000;
    m_lvl = 0;
    m_seen = 1'b0;
    foreach (m_ctr[i]) m_ctr[i] = 0;
    arst_n = 1'b0;
    repeat (4) @(negedge clk);
    arst_n = 1'b1;
    // reset values and an unmapped word
    bus_rd(OFS_COMMIT, 4'hF, 32'h0);
    bus_rd(OFS_LED, 4'hF, 32'h0);
    bus_rd(8'h3C, 4'hF, 32'h0);
    $display("test reset values done");
    // led value goes out inverted, only while no rom strobe is active
    r = rnd();
    bus_wr(OFS_LED, 4'h1, {24'h0, r[7:0]});
    @(negedge clk);
    chk({24'h0, pins}, {24'h0, ~r[7:0]});
    for (int i = 0; i < 4; i++) begin
      @(negedge clk);
      {hle, lle, oe_n} = (i == 0) ? 3'b101 : (i == 1) ? 3'b011 : (i == 2) ? 3'b000 : 3'b001;
      #1;
      chk({31'h0, oe}, {31'h0, i == 3});
    end
    $display("test led pins done");
    // nibble write refused while running; option bits reach the media pins
    run_ctl = 1'b1;
    bus_wr(OFS_COMMIT, 4'h8, 32'h3F00_0000);
    bus_rd(OFS_COMMIT, 4'h8, 32'h0E00_0000);
    run_ctl = 1'b0;
    bus_wr(OFS_COMMIT, 4'h8, 32'h3F00_0000);
    bit_rate_phy_select = 1'b1;
    repeat (3) @(negedge clk);
    chk({28'h0, b3, b2, b1, txer}, 32'hE);
    chk({28'h0, opts}, 32'hE);
    chk({28'h0, level}, 32'h3);
    bus_wr(OFS_COMMIT, 4'h8, 32'h3500_0000);
    repeat (2) @(negedge clk);
    chk({28'h0, b3, b2, b1, txer}, 32'h4);
    bit_rate_phy_select = 1'b0;
    repeat (2) @(negedge clk);
    chk({28'h0, b3, b2, b1, txer}, 32'h0);
    $display("test commit register done");
    // start threshold for every code, then the deadlock escape
    for (int l = 0; l < 8; l++) begin
      bus_wr(OFS_COMMIT, 4'h8, {l[3:0], 28'h0});
      thr = 64 << l;
      fifo_bytes = (l < 5) ? 12'(thr - 1) : 12'hFFF;
      #1;
      chk({31'h0, start_ok}, 32'h0);
      @(negedge clk);
      if (l < 5) fifo_bytes = 12'(thr);
      else frame_in = 1'b1;
      #1;
      chk({31'h0, start_ok}, 32'h1);
      @(negedge clk);
      {frame_in, wait_data, wait_space, fifo_bytes} = {3'b010, 12'h000};
      #1;
      chk({31'h0, start_ok}, 32'h0);
      @(negedge clk);
      wait_space = 1'b1;
      #1;
      chk({31'h0, start_ok}, {31'h0, l >= 3});
      @(negedge clk);
      {wait_data, wait_space} = 2'b00;
    end
    $display("test start threshold done");
    // back-to-back underruns climb by one and stop at seven
    bus_wr(OFS_COMMIT, 4'h8, 32'h5000_0000);
    m_lvl = 5;
    run_ctl = 1'b1;
    repeat (4) step(7'b0100000, 1'b0);
    step('0, 1'b0);
    chk({28'h0, level}, m_lvl);
    $display("test underrun adapt done");
    // random traffic, then byte-wise reads that clear what they return
    repeat (300) begin
      r = rnd();
      step(tcls_stat_ev_t'({r[0], r[1] & r[2] & r[3], r[5], r[6], r[7], r[8], r[9] & r[10]}),
        r[11] & r[12]);
    end
    chk_ovf();
    bus_wr(OFS_STAT_RX, 4'hF, 32'hFFFF_FFFF);
    bus_rd(OFS_STAT_RX, 4'h1, {24'h0, m_ctr[0][7:0]});
    m_ctr[0] &= 32'hFFFF00;
    bus_rd(OFS_STAT_RX, 4'hE, {m_ctr[1][7:0], m_ctr[0][23:0]});
    bus_rd(OFS_STAT_TX, 4'hF, {m_ctr[3][7:0], m_ctr[2][23:0]});
    bus_rd(OFS_STAT_ERR, 4'hC, {m_ctr[5][7:0], m_ctr[4][7:0], 16'h0});
    foreach (m_ctr[i]) m_ctr[i] = 0;
    bus_rd(OFS_STAT_RX, 4'hF, 32'h0);
    chk_ovf();
    $display("test statistics done");
    // overflow flag at the msb, wrap after the maximum
    repeat (127) step(7'b0101000, 1'b0);
    chk_ovf();
    step(7'b0101000, 1'b0);
    chk_ovf();
    repeat (128) step(7'b0101000, 1'b0);
    chk_ovf();
    bus_rd(OFS_STAT_RX, 4'h8, 32'h0);
    bus_rd(OFS_STAT_TX, 4'h8, 32'h0);
    $display("test overflow and wrap done");
    // adapter reset and bus reset both clear the two registers
    run_ctl = 1'b0;
    for (int i = 0; i < 2; i++) begin
      bus_wr(OFS_COMMIT, 4'h8, 32'h7E00_0000);
      bus_wr(OFS_LED, 4'h1, 32'hFF);
      {adp_rst, bus_rst_n} = (i == 0) ? 2'b11 : 2'b00;
      @(negedge clk);
      {adp_rst, bus_rst_n} = 2'b01;
      bus_rd(OFS_COMMIT, 4'h8, 32'h0);
      bus_rd(OFS_LED, 4'h1, 32'h0);
    end
    $display("test soft resets done");
    results();
  end
endmodule : tb_top
